// File: include/imd_pkg.sv
// Package: register map, field layout, reset values and timing of the interrupt block
`default_nettype none
package imd_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] STATUS_IDX = 8'h7f;
	localparam logic [7:0] MASK_IDX = 8'h80;
	localparam logic [7:0] POLARITY_IDX = 8'h81;
	localparam logic [7:0] DEBOUNCE_IDX = 8'h82;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int NUM_SRC = 4;

	// Source numbering inside the block
	localparam int SRC_LOCK = 0;
	localparam int SRC_PIN1 = 1;
	localparam int SRC_SEQ = 2;
	localparam int SRC_PIN4 = 3;

	// Field positions: event bits common to status, mask, polarity and debounce, combined bit in status only
	localparam int LOCK_EVENT_BIT = 2;
	localparam int PIN1_EVENT_BIT = 5;
	localparam int SEQ_EVENT_BIT = 8;
	localparam int PIN4_EVENT_BIT = 9;
	localparam int COMBINED_BIT = 10;

	// Reset values
	localparam logic [REG_W-1:0] MASK_RESET = 16'h0324;
	localparam logic [REG_W-1:0] POLARITY_RESET = 16'h0000;
	localparam logic [REG_W-1:0] DEBOUNCE_RESET = 16'h0000;

	// Debounce: a new level must stand this long before it is passed on
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEBOUNCE_TIME_NS = 40;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DB_CNT_W = 3;

endpackage
`default_nettype wire

// File: include/imd_filter_if.sv
// Interface: raw sources, debounce enables and filtered levels between top and filter
`default_nettype none
interface imd_filter_if;
	logic [imd_pkg::NUM_SRC-1:0] raw;
	logic [imd_pkg::NUM_SRC-1:0] enable;
	logic [imd_pkg::NUM_SRC-1:0] filtered;

	modport filter (input raw, input enable, output filtered);
	modport user (output raw, output enable, input filtered);
endinterface
`default_nettype wire

// File: rtl/imd_debounce.sv
// Debounce filter: one counter per source, bypassed when its enable is low
`default_nettype none
module imd_debounce (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	imd_filter_if.filter flt
);

	localparam logic [imd_pkg::DB_CNT_W-1:0] DB_LAST =
		imd_pkg::DB_CNT_W'(imd_pkg::DEBOUNCE_CYCLES - 1);

	logic [imd_pkg::NUM_SRC-1:0] stable_r;
	logic [imd_pkg::NUM_SRC-1:0] stable_nxt;

	genvar g;
	generate
		for (g = 0; g < imd_pkg::NUM_SRC; g++) begin : g_src
			logic [imd_pkg::DB_CNT_W-1:0] cnt_r;
			logic [imd_pkg::DB_CNT_W-1:0] cnt_nxt;

			// Count samples that differ from the held level
			always_comb begin
				cnt_nxt = '0;
				stable_nxt[g] = stable_r[g];
				if (flt.raw[g] != stable_r[g]) begin
					if (cnt_r == DB_LAST) begin
						stable_nxt[g] = flt.raw[g]; // see RULE_12
					end else begin
						cnt_nxt = cnt_r + 1'b1;
					end
				end
			end

			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					cnt_r <= '0;
					stable_r[g] <= 1'b0;
				end else begin
					cnt_r <= cnt_nxt;
					stable_r[g] <= stable_nxt[g];
				end
			end

			// Filter or bypass per enable
			assign flt.filtered[g] = flt.enable[g] ? stable_r[g] : flt.raw[g]; // see RULE_07
		end
	endgenerate

endmodule
`default_nettype wire

// File: rtl/imd_top.sv
// Interrupt mask, polarity and debounce block with Avalon-MM register slave
// Behaviour
// RULE_01: Mask bit 1 blocks its flag from the combined interrupt; all masks reset to 1.
// RULE_02: Sequencer mask at bit 8, first pin mask at bit 5.
// RULE_03: Lock mask at bit 2, bit-clock pin mask at bit 9.
// RULE_04: Sequencer polarity bit 8: 0 raises when busy, 1 when idle; resets 0.
// RULE_05: Lock polarity bit 2: 0 raises on lock, 1 while unlocked; resets 0.
// RULE_06: Pin polarity bits 9 and 5: 0 active high, 1 active low; reset 0.
// RULE_07: Sequencer debounce bit 8 filters its input when 1, bypasses when 0.
// RULE_08: Debounce bits 9, 5, 2 enable filtering when 1; all reset 0.
// RULE_09: Status bit 10 is the OR of the event flags; the code ORs only the unmasked flags.
// RULE_10: Flags stay set until a one is written to them; zero leaves them.
// RULE_11: Software ignores the sequencer flag read while the sequencer is busy.
// RULE_12: With debounce on, a new level must hold several samples before it counts.
//
// Implementation choice: the Avalon-MM slave port.
`default_nettype none
module imd_top (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [imd_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [imd_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [imd_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic pin1_i,
	input wire logic pin4_i,
	input wire logic seq_busy_i,
	input wire logic fll_lock_i,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Field mapping helpers

	// Spread per-source bits onto their register positions
	function automatic logic [imd_pkg::REG_W-1:0] to_field(input logic [imd_pkg::NUM_SRC-1:0] v);
		logic [imd_pkg::REG_W-1:0] w;
		w = '0;
		w[imd_pkg::LOCK_EVENT_BIT] = v[imd_pkg::SRC_LOCK]; // see RULE_03
		w[imd_pkg::PIN1_EVENT_BIT] = v[imd_pkg::SRC_PIN1]; // see RULE_02
		w[imd_pkg::SEQ_EVENT_BIT] = v[imd_pkg::SRC_SEQ]; // see RULE_02
		w[imd_pkg::PIN4_EVENT_BIT] = v[imd_pkg::SRC_PIN4]; // see RULE_03
		return w;
	endfunction

	// Gather register positions back into per-source bits
	function automatic logic [imd_pkg::NUM_SRC-1:0] from_field(input logic [imd_pkg::REG_W-1:0] w);
		logic [imd_pkg::NUM_SRC-1:0] v;
		v = '0;
		v[imd_pkg::SRC_LOCK] = w[imd_pkg::LOCK_EVENT_BIT];
		v[imd_pkg::SRC_PIN1] = w[imd_pkg::PIN1_EVENT_BIT];
		v[imd_pkg::SRC_SEQ] = w[imd_pkg::SEQ_EVENT_BIT];
		v[imd_pkg::SRC_PIN4] = w[imd_pkg::PIN4_EVENT_BIT];
		return v;
	endfunction

	// Register index of a byte address; the two low bits are ignored
	function automatic logic [7:0] reg_index(input logic [imd_pkg::ADDR_W-1:0] a);
		return a[imd_pkg::ADDR_W-1:2];
	endfunction

	// Replace only the bits whose byte lane is enabled
	function automatic logic [imd_pkg::NUM_SRC-1:0] merge_lanes(
		input logic [imd_pkg::NUM_SRC-1:0] old_v,
		input logic [imd_pkg::NUM_SRC-1:0] new_v,
		input logic [imd_pkg::NUM_SRC-1:0] lane_v
	);
		return (old_v & ~lane_v) | (new_v & lane_v);
	endfunction

	// Read data word for a register index; unmapped indices read zero
	function automatic logic [imd_pkg::DATA_W-1:0] read_word(
		input logic [7:0] i,
		input logic [imd_pkg::REG_W-1:0] status_v,
		input logic [imd_pkg::NUM_SRC-1:0] mask_v,
		input logic [imd_pkg::NUM_SRC-1:0] pol_v,
		input logic [imd_pkg::NUM_SRC-1:0] db_v
	);
		logic [imd_pkg::REG_W-1:0] w;
		w = '0;
		unique case (i)
			imd_pkg::STATUS_IDX: w = status_v;
			imd_pkg::MASK_IDX: w = to_field(mask_v);
			imd_pkg::POLARITY_IDX: w = to_field(pol_v);
			imd_pkg::DEBOUNCE_IDX: w = to_field(db_v);
			default: w = '0;
		endcase
		return {16'h0000, w};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Configuration and flag state

	logic [imd_pkg::NUM_SRC-1:0] mask_r;
	logic [imd_pkg::NUM_SRC-1:0] mask_nxt;
	logic [imd_pkg::NUM_SRC-1:0] pol_r;
	logic [imd_pkg::NUM_SRC-1:0] pol_nxt;
	logic [imd_pkg::NUM_SRC-1:0] db_r;
	logic [imd_pkg::NUM_SRC-1:0] db_nxt;
	logic [imd_pkg::NUM_SRC-1:0] flag_r;
	logic [imd_pkg::NUM_SRC-1:0] flag_nxt;
	logic irq_r;
	logic irq_nxt;

	logic [imd_pkg::DATA_W-1:0] rdata_r;
	logic [imd_pkg::DATA_W-1:0] rdata_nxt;
	logic wait_r;
	logic wait_nxt;

	logic [imd_pkg::NUM_SRC-1:0] active;
	logic [imd_pkg::NUM_SRC-1:0] wr_bits;
	logic [imd_pkg::REG_W-1:0] wr_word;
	logic [imd_pkg::REG_W-1:0] lane_mask;
	logic wr_take;
	logic rd_take;
	logic [7:0] idx;
	logic [imd_pkg::NUM_SRC-1:0] src_level;
	logic [imd_pkg::NUM_SRC-1:0] lane_bits;
	logic [imd_pkg::NUM_SRC-1:0] clear_bits;
	logic [imd_pkg::NUM_SRC-1:0] open_flags;
	logic [imd_pkg::REG_W-1:0] status_word;
	logic hit_status;
	logic hit_mask;
	logic hit_pol;
	logic hit_db;
	logic combined;
	logic req;

	////////////////////////////////////////////////////////////////////////////
	// Source conditioning

	imd_filter_if flt ();

	// Gather the four source levels in block order
	always_comb begin
		src_level = '0;
		src_level[imd_pkg::SRC_LOCK] = fll_lock_i; // see RULE_05
		src_level[imd_pkg::SRC_PIN1] = pin1_i; // see RULE_06
		src_level[imd_pkg::SRC_SEQ] = seq_busy_i; // see RULE_04
		src_level[imd_pkg::SRC_PIN4] = pin4_i; // see RULE_06
	end

	// Polarity selects which level of each source counts as active
	assign flt.raw = src_level ^ pol_r; // see RULE_04 RULE_05 RULE_06
	assign flt.enable = db_r; // see RULE_08

	imd_debounce u_debounce (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.flt(flt.filter)
	);

	assign active = flt.filtered;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Request is taken in the first cycle, committed when waitrequest is low
	assign idx = reg_index(avs_address_i);
	assign wr_take = avs_write_i && !wait_r;
	assign rd_take = avs_read_i && wait_r;
	assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign wr_word = avs_writedata_i[imd_pkg::REG_W-1:0] & lane_mask;
	assign wr_bits = from_field(wr_word);
	assign lane_bits = from_field(lane_mask);
	assign req = avs_read_i || avs_write_i;

	////////////////////////////////////////////////////////////////////////////
	// Write strobes

	// One strobe per register, only in the cycle the write commits
	assign hit_status = wr_take && (idx == imd_pkg::STATUS_IDX);
	assign hit_mask = wr_take && (idx == imd_pkg::MASK_IDX);
	assign hit_pol = wr_take && (idx == imd_pkg::POLARITY_IDX);
	assign hit_db = wr_take && (idx == imd_pkg::DEBOUNCE_IDX);
	// Ones written to the status register clear flags
	assign clear_bits = hit_status ? wr_bits : '0;

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Byte lanes 0 and 1 gate the low and high bytes of a write
	always_comb begin
		mask_nxt = mask_r;
		pol_nxt = pol_r;
		db_nxt = db_r;
		if (hit_mask) begin
			mask_nxt = merge_lanes(mask_r, wr_bits, lane_bits); // see RULE_01
		end
		if (hit_pol) begin
			pol_nxt = merge_lanes(pol_r, wr_bits, lane_bits); // see RULE_04 RULE_05 RULE_06
		end
		if (hit_db) begin
			db_nxt = merge_lanes(db_r, wr_bits, lane_bits); // see RULE_07 RULE_08
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mask_r <= from_field(imd_pkg::MASK_RESET); // see RULE_01
			pol_r <= from_field(imd_pkg::POLARITY_RESET); // see RULE_04
			db_r <= from_field(imd_pkg::DEBOUNCE_RESET); // see RULE_08
		end else begin
			mask_r <= mask_nxt;
			pol_r <= pol_nxt;
			db_r <= db_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky event flags

	always_comb begin
		// Keep a flag unless a one is written to it
		flag_nxt = flag_r & ~clear_bits; // see RULE_10
		// Set wins over a clear in the same cycle
		flag_nxt = flag_nxt | active;
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			flag_r <= '0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt line

	// Computed from next values so the line moves on the same edge as the flags
	assign open_flags = flag_nxt & ~mask_nxt;

	always_comb begin
		irq_nxt = |open_flags; // see RULE_01
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	// Combined bit seen by software, equal to what the interrupt line shows
	assign combined = |(flag_r & ~mask_r); // see RULE_09

	always_comb begin
		status_word = to_field(flag_r);
		status_word[imd_pkg::COMBINED_BIT] = combined; // see RULE_09
	end

	// Captured at the request edge, shown while waitrequest is low
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_take) begin
			rdata_nxt = read_word(idx, status_word, mask_r, pol_r, db_r);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Handshake

	// One wait cycle, then a single cycle with waitrequest low
	// A request seen while waitrequest is high is answered on the next edge
	always_comb begin
		wait_nxt = !(req && wait_r);
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= wait_nxt;
		end
	end

	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;
	assign irq_o = irq_r;

endmodule
`default_nettype wire

// File: verif/imd_top_assertions.sv
// Checker: bus handshake, read data layout and interrupt output
`default_nettype none
module imd_top_assertions (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [imd_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic [imd_pkg::DATA_W-1:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////////////////
	a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("waitrequest not low after request");
	a_wait_single_low: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	a_read_answer_bound: assert property ($rose(avs_read_i) |-> ##[0:2] !avs_waitrequest_o)
		else $error("read not answered in time");
	a_read_data_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data changed without a read");
	a_reserved_bits_zero: assert property ((avs_readdata_o & ~32'h0000_0724) == 32'h0)
		else $error("reserved read data bit set");
	a_irq_reset_masked: assert property ($fell(sys_rst_i) |-> !irq_o [*2])
		else $error("interrupt raised with all sources masked");
	a_irq_sticky_level: assert property (irq_o && !(avs_write_i && !avs_waitrequest_o)
		|=> irq_o) else $error("interrupt dropped without a register write");
	a_status_combined_irq: assert property (avs_read_i && avs_waitrequest_o
		&& avs_address_i == {imd_pkg::STATUS_IDX, 2'b00}
		|=> avs_readdata_o[imd_pkg::COMBINED_BIT] == $past(irq_o))
		else $error("combined status bit differs from interrupt line");
endmodule
bind imd_top imd_top_assertions u_chk (.*);
`default_nettype wire

// File: verif/tb_top.sv
// Testbench: registers, source polarity, sticky flags, masks and debounce
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] ST = 10'h1fc, MK = 10'h200, PL = 10'h204, DB = 10'h208;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [9:0] avs_address_i = 10'h000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic irq_o;
	logic [15:0] src_lvl = 16'h0000;
	int errors = 0;
	int checks_done = 0;
	imd_top dut (.*, .pin1_i(src_lvl[5]), .pin4_i(src_lvl[9]), .seq_busy_i(src_lvl[8]),
		.fll_lock_i(src_lvl[2]));
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk_i);
			if (!avs_waitrequest_o) break;
		end
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n == 20) begin
			errors++;
			$display("MISMATCH waitrequest expected 0 seen 1");
			finish_test();
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), exp, q);
	endtask
	task automatic irq_chk(input logic exp);
		@(negedge sys_clk_i);
		chk("irq", {31'h0, exp}, {31'h0, irq_o});
	endtask
	task automatic pulse(input int b, input int n);
		@(posedge sys_clk_i);
		src_lvl[b] <= 1'b1;
		repeat (n) @(posedge sys_clk_i);
		src_lvl[b] <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(MK, 32'h0324);
		rd(PL, 32'h0);
		rd(DB, 32'h0);
		avs_byteenable_i <= 4'h1;
		wr(MK, 32'h0);
		avs_byteenable_i <= 4'hf;
		rd(MK, 32'h0300);
		wr(MK, 32'h0324);
		wr(10'h20c, 32'hffff);
		rd(10'h20c, 32'h0);
		irq_chk(1'b0);
	endtask
	task automatic t_polarity();
		int bits[4] = '{2, 5, 8, 9};
		foreach (bits[i]) begin
			wr(PL, 32'h1 << bits[i]);
			repeat (3) @(posedge sys_clk_i);
			rd(ST, 32'h1 << bits[i]);
			wr(PL, 32'h0);
			wr(ST, 32'h1 << bits[i]);
			rd(ST, 32'h0);
			wr(MK, 32'h0324 & ~(32'h1 << bits[i]));
			pulse(bits[i], 1);
			rd(ST, 32'h0400 | (32'h1 << bits[i]));
			irq_chk(1'b1);
			wr(ST, 32'h0);
			irq_chk(1'b1);
			wr(ST, 32'h1 << bits[i]);
			irq_chk(1'b0);
			wr(MK, 32'h0324);
		end
	endtask
	task automatic t_debounce();
		int bits[4] = '{2, 5, 8, 9};
		wr(DB, 32'h0324);
		rd(DB, 32'h0324);
		foreach (bits[i]) begin
			pulse(bits[i], 3);
			rd(ST, 32'h0);
			pulse(bits[i], 4);
			rd(ST, 32'h1 << bits[i]);
			wr(ST, 32'h1 << bits[i]);
		end
		wr(DB, 32'h0);
	endtask
	task automatic t_mid_reset();
		wr(MK, 32'h0);
		wr(PL, 32'h0004);
		repeat (2) @(posedge sys_clk_i);
		irq_chk(1'b1);
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		irq_chk(1'b0);
		rd(MK, 32'h0324);
		rd(PL, 32'h0);
		rd(ST, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_polarity();
		t_debounce();
		t_mid_reset();
		finish_test();
	end
endmodule
`default_nettype wire
